// [rtl/buck_pwm_subtimer.sv]
// Purpose: One PWM subtimer for a buck stage with midpoint ADC trigger.
// Assumes: One clock mclk, synchronous active-low reset.
// Notes: Dead-time and the complementary channel are not present.
//
// How it works
// - Counter counts up and restarts from zero each period in continuous mode.
// - Counter wraps at the active period value, giving a period event.
// - Period event drives the channel active when set source selected.
// - Duty compare match drives the channel inactive when selected.
// - With shadowing and update-on-reset, duty written during the interrupt applies from next period.
// - With shadowing on, period and compare writes take effect only at an update event.
// - Sample compare match gives an ADC trigger event apart from PWM.
// - Counter reset sets a flag; enabled flag raises the interrupt line.
// - With shadowing, writes go to shadows until an update transfers.
// - Update-on-reset makes every counter reset an update event.
// - Channel reaches the pin only while its output enable is one.
// - Counter advances only while the count enable bit is one.
// - Repetition count zero gives a repetition event every period.
// - Repetition count n gives one repetition event per n+1 periods.
// - ADC trigger output fires on sample match when selected, else never.
// - Soft update bit forces an immediate shadow to active transfer.
`timescale 1ns/1ps
`default_nettype none
module buck_pwm_subtimer #(
  parameter int CNT_W = buck_pwm_pkg::CNT_W,
  parameter int REP_W = buck_pwm_pkg::REP_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire buck_pwm_pkg::bus_req_t bus_req,
  output logic [buck_pwm_pkg::DATA_W-1:0] rdata,
  output logic channel0_pin,
  output logic adc_trigger_out_zero,
  output logic subtimer_irq_line
);
  import buck_pwm_pkg::*;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic first_subtimer_count_enable;
  logic continuous_run_select;
  logic shadow_enable;
  logic update_on_counter_reset;
  logic counter_reset_irq_enable;
  logic rep_irq_enable;
  logic channel0_output_enable;
  logic set_on_period_sel;
  logic clear_on_duty_match_sel;
  logic trig_on_sample_sel;
  logic [CNT_W-1:0] period_reload_reg;
  logic [CNT_W-1:0] duty_compare_reg;
  logic [CNT_W-1:0] sample_compare_reg;
  logic [REP_W-1:0] repetition_count_reg;
  logic [CNT_W-1:0] period_act;
  logic [CNT_W-1:0] duty_act;
  logic [CNT_W-1:0] sample_act;
  logic [REP_W-1:0] rep_act;

  // Core state
  cnt_state_t state_reg;
  cnt_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [REP_W-1:0] rep_cnt_reg;
  logic chan_reg;
  logic chan_next;
  logic rst_flag_reg;
  logic rep_flag_reg;

  // Decoded strobes and events
  logic wr_hit;
  logic first_subtimer_soft_update;
  logic status_clr_rst;
  logic status_clr_rep;
  logic run;
  logic per_hit;
  logic duty_hit;
  logic first_subtimer_sample_match;
  logic rep_hit;
  logic upd;

  assign wr_hit = bus_req.wr;
  assign first_subtimer_soft_update = wr_hit &&
    bus_req.addr == OFS_SOFT_UPD && bus_req.wdata[BIT_SOFT_UPD];
  assign status_clr_rst = wr_hit && bus_req.addr == OFS_STATUS &&
    bus_req.wdata[BIT_RST_IE];
  assign status_clr_rep = wr_hit && bus_req.addr == OFS_STATUS &&
    bus_req.wdata[BIT_REP_IE];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control bits
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      first_subtimer_count_enable <= 1'b0;
      continuous_run_select <= 1'b1;
      shadow_enable <= 1'b0;
      update_on_counter_reset <= 1'b0;
      counter_reset_irq_enable <= 1'b0;
      rep_irq_enable <= 1'b0;
      channel0_output_enable <= 1'b0;
      set_on_period_sel <= 1'b0;
      clear_on_duty_match_sel <= 1'b0;
      trig_on_sample_sel <= 1'b0;
    end else if (wr_hit) begin
      case (bus_req.addr)
        OFS_MASTER_CTL: begin
          first_subtimer_count_enable <= bus_req.wdata[BIT_COUNT_EN];
        end
        OFS_SUB_CTL: begin
          continuous_run_select <= bus_req.wdata[BIT_CONT_RUN];
          shadow_enable <= bus_req.wdata[BIT_SHADOW_EN];
          update_on_counter_reset <= bus_req.wdata[BIT_UPD_ON_RST];
        end
        OFS_IRQ_EN: begin
          counter_reset_irq_enable <= bus_req.wdata[BIT_RST_IE];
          rep_irq_enable <= bus_req.wdata[BIT_REP_IE];
        end
        OFS_OUT_EN: begin
          channel0_output_enable <= bus_req.wdata[BIT_CH0_OE];
        end
        OFS_CHAN_CFG: begin
          set_on_period_sel <= bus_req.wdata[BIT_SET_PER];
          clear_on_duty_match_sel <= bus_req.wdata[BIT_CLR_DUTY];
        end
        OFS_ADC_CFG: begin
          trig_on_sample_sel <= bus_req.wdata[BIT_TRIG_SAMPLE];
        end
        default: begin
        end
      endcase
    end
  end

  // Shadow values, writable at any time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      period_reload_reg <= PERIOD_RST;
      duty_compare_reg <= CMP_RST;
      sample_compare_reg <= CMP_RST;
      repetition_count_reg <= REP_RST;
    end else if (wr_hit) begin
      case (bus_req.addr)
        OFS_PERIOD: period_reload_reg <= bus_req.wdata[CNT_W-1:0];
        OFS_DUTY: duty_compare_reg <= bus_req.wdata[CNT_W-1:0];
        OFS_SAMPLE: sample_compare_reg <= bus_req.wdata[CNT_W-1:0];
        OFS_REP: repetition_count_reg <= bus_req.wdata[REP_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shadow to active transfer
  // ----------------------------------------------------------------
  // Update on counter reset or software request
  assign upd = (update_on_counter_reset && per_hit) ||
    first_subtimer_soft_update;

  // Shadows take effect only at upd while shadowing is on
  preload_reg #(.W(CNT_W), .RESET_VAL(PERIOD_RST)) u_period (
    .mclk(mclk), .rst_n(rst_n), .shadow_val(period_reload_reg),
    .load(upd), .bypass(!shadow_enable), .active_val(period_act));
  preload_reg #(.W(CNT_W), .RESET_VAL(CMP_RST)) u_duty (
    .mclk(mclk), .rst_n(rst_n), .shadow_val(duty_compare_reg),
    .load(upd), .bypass(!shadow_enable), .active_val(duty_act));
  preload_reg #(.W(CNT_W), .RESET_VAL(CMP_RST)) u_sample (
    .mclk(mclk), .rst_n(rst_n), .shadow_val(sample_compare_reg),
    .load(upd), .bypass(!shadow_enable), .active_val(sample_act));
  preload_reg #(.W(REP_W), .RESET_VAL(REP_RST)) u_rep (
    .mclk(mclk), .rst_n(rst_n), .shadow_val(repetition_count_reg),
    .load(upd), .bypass(!shadow_enable), .active_val(rep_act));

  // ----------------------------------------------------------------
  // Counter and events
  // ----------------------------------------------------------------
  // Match decode on the running count
  always_comb begin
    run = (state_reg == ST_RUN);
    per_hit = run && (cnt_reg == period_act);
    duty_hit = run && (cnt_reg == duty_act);
    first_subtimer_sample_match = run && (cnt_reg == sample_act);
    rep_hit = per_hit && (rep_cnt_reg == '0);
  end

  // Run control; single-shot holds after its one period
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (first_subtimer_count_enable) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!first_subtimer_count_enable) begin
          state_next = ST_IDLE;
        end else if (per_hit && !continuous_run_select) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!first_subtimer_count_enable) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Up counter, restart from zero at the period value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (per_hit) begin
      cnt_reg <= '0;
    end else if (run) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Repetition down counter, reload after reaching zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rep_cnt_reg <= '0;
    end else if (rep_hit) begin
      rep_cnt_reg <= rep_act;
    end else if (per_hit) begin
      rep_cnt_reg <= rep_cnt_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Channel, pin and ADC trigger
  // ----------------------------------------------------------------
  // Duty clear wins over period set in the same cycle
  always_comb begin
    chan_next = chan_reg;
    if (duty_hit && clear_on_duty_match_sel) begin
      chan_next = 1'b0;
    end else if (per_hit && set_on_period_sel) begin
      chan_next = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chan_reg <= 1'b0;
      channel0_pin <= 1'b0;
      adc_trigger_out_zero <= 1'b0;
    end else begin
      chan_reg <= chan_next;
      channel0_pin <= chan_next && channel0_output_enable;
      adc_trigger_out_zero <= first_subtimer_sample_match &&
        trig_on_sample_sel;
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt line
  // ----------------------------------------------------------------
  // Sticky flags, write one to clear, a new event wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rst_flag_reg <= 1'b0;
      rep_flag_reg <= 1'b0;
      subtimer_irq_line <= 1'b0;
    end else begin
      rst_flag_reg <= per_hit || (rst_flag_reg && !status_clr_rst);
      rep_flag_reg <= rep_hit || (rep_flag_reg && !status_clr_rep);
      subtimer_irq_line <= (rst_flag_reg && counter_reset_irq_enable) ||
        (rep_flag_reg && rep_irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Read port, data in the cycle after the strobe only
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (bus_req.rd) begin
      rdata <= '0;
      case (bus_req.addr)
        OFS_MASTER_CTL: rdata[BIT_COUNT_EN] <= first_subtimer_count_enable;
        OFS_SUB_CTL: begin
          rdata[BIT_CONT_RUN] <= continuous_run_select;
          rdata[BIT_SHADOW_EN] <= shadow_enable;
          rdata[BIT_UPD_ON_RST] <= update_on_counter_reset;
        end
        OFS_PERIOD: rdata[CNT_W-1:0] <= period_reload_reg;
        OFS_DUTY: rdata[CNT_W-1:0] <= duty_compare_reg;
        OFS_SAMPLE: rdata[CNT_W-1:0] <= sample_compare_reg;
        OFS_REP: rdata[REP_W-1:0] <= repetition_count_reg;
        OFS_IRQ_EN: begin
          rdata[BIT_RST_IE] <= counter_reset_irq_enable;
          rdata[BIT_REP_IE] <= rep_irq_enable;
        end
        OFS_STATUS: begin
          rdata[BIT_RST_IE] <= rst_flag_reg;
          rdata[BIT_REP_IE] <= rep_flag_reg;
        end
        OFS_OUT_EN: rdata[BIT_CH0_OE] <= channel0_output_enable;
        OFS_CHAN_CFG: begin
          rdata[BIT_SET_PER] <= set_on_period_sel;
          rdata[BIT_CLR_DUTY] <= clear_on_duty_match_sel;
        end
        OFS_ADC_CFG: rdata[BIT_TRIG_SAMPLE] <= trig_on_sample_sel;
        OFS_COUNT: rdata[CNT_W-1:0] <= cnt_reg;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_wrap_at_period: assert property (per_hit |=> cnt_reg == '0)
    else $error("counter did not wrap after period");
  a_count_advance: assert property (run && !per_hit && state_next == ST_RUN
    |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("counter did not advance");
  a_count_stopped: assert property (!run |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  a_set_period: assert property (per_hit && set_on_period_sel &&
    !(duty_hit && clear_on_duty_match_sel) && channel0_output_enable
    |=> channel0_pin)
    else $error("pin not set on period");
  a_clear_duty: assert property (duty_hit && clear_on_duty_match_sel
    |=> !channel0_pin && !chan_reg)
    else $error("pin not cleared on duty match");
  a_pin_gate: assert property (!channel0_output_enable |=> !channel0_pin)
    else $error("pin driven while output disabled");
  a_shadow_hold: assert property (shadow_enable && !upd
    |=> $stable(duty_act) && $stable(period_act))
    else $error("active value changed without update");
  a_update_copy: assert property (upd |=> duty_act == $past(duty_compare_reg)
    && period_act == $past(period_reload_reg))
    else $error("update did not transfer shadows");
  a_soft_update: assert property (first_subtimer_soft_update
    |=> sample_act == $past(sample_compare_reg))
    else $error("soft update did not transfer");
  a_adc_trigger: assert property (first_subtimer_sample_match
    |=> adc_trigger_out_zero == $past(trig_on_sample_sel))
    else $error("adc trigger mismatch");
  a_adc_pulse: assert property (adc_trigger_out_zero
    |=> !adc_trigger_out_zero)
    else $error("adc trigger longer than one cycle");
  a_reset_flag: assert property (per_hit && counter_reset_irq_enable
    ##1 counter_reset_irq_enable |=> subtimer_irq_line)
    else $error("interrupt not raised after counter reset");
  a_rep_zero: assert property (per_hit && rep_cnt_reg == '0 |=> rep_flag_reg)
    else $error("repetition event missed at zero");
  a_rep_count: assert property (per_hit && rep_cnt_reg != '0
    |=> rep_cnt_reg == $past(rep_cnt_reg) - 1'b1)
    else $error("repetition count did not step");

  c_period_event: cover property (per_hit ##1 subtimer_irq_line);
  c_adc_trigger: cover property (adc_trigger_out_zero);
  c_rep_divided: cover property (per_hit && rep_act != '0 && !rep_hit);
  c_soft_update: cover property (first_subtimer_soft_update && shadow_enable);

endmodule // buck_pwm_subtimer
`default_nettype wire

// [rtl/buck_pwm_pkg.sv]
// Purpose: Shared constants and types for the buck PWM subtimer.
// Assumes: One timer clock, 32-bit register port with byte addresses.
// Notes: Field positions are bit indices inside their register word.
package buck_pwm_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int REP_W = 8;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h8700; // 34560 counts
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic [REP_W-1:0] REP_RST = 8'h00;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MASTER_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SUB_CTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DUTY = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REP = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_OUT_EN = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CHAN_CFG = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_ADC_CFG = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_SOFT_UPD = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_COUNT_EN = 0;     // master control
  localparam int BIT_CONT_RUN = 0;     // subtimer control
  localparam int BIT_SHADOW_EN = 1;
  localparam int BIT_UPD_ON_RST = 2;
  localparam int BIT_RST_IE = 0;       // irq enable and status
  localparam int BIT_REP_IE = 1;
  localparam int BIT_CH0_OE = 0;       // output enable
  localparam int BIT_SET_PER = 0;      // channel config
  localparam int BIT_CLR_DUTY = 1;
  localparam int BIT_TRIG_SAMPLE = 0;  // adc trigger config
  localparam int BIT_SOFT_UPD = 0;     // soft update

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b11
  } cnt_state_t;

endpackage

// [rtl/preload_reg.sv]
// Purpose: Active copy of one shadowed value.
// Assumes: Shadow value held by the caller's register file.
// Notes: With bypass high the active copy follows the shadow.
`timescale 1ns/1ps
`default_nettype none
module preload_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] shadow_val,
  input wire logic load,
  input wire logic bypass,
  output logic [W-1:0] active_val
);

  // Transfer on update event or follow directly when not shadowed
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_val <= RESET_VAL;
    end else if (load || bypass) begin
      active_val <= shadow_val;
    end
  end

endmodule // preload_reg
`default_nettype wire

// [verif/gate_adc_model.sv]
// Purpose: Far-side model of the gate driver and the ADC trigger input.
// Assumes: Gate and trigger are sampled on rising mclk edges.
// Notes: Records on-time, trigger spacing and offset from the gate rise.
`timescale 1ns/1ps
`default_nettype none
module gate_adc_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic gate,
  input wire logic trig,
  output logic [15:0] high_len,
  output logic [15:0] n_pulses,
  output logic [15:0] trig_gap,
  output logic [15:0] trig_ofs,
  output logic [15:0] conv_count
);
  logic gate_d, trig_d;
  logic [15:0] run, since_rise, since_trig;

  // ----------------------------------------------------------------
  // Gate driver: on-time of the last finished pulse
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    gate_d <= rst_n & gate;
    run <= (rst_n && gate) ? run + 16'h1 : 16'h0;
    since_rise <= (gate && !gate_d) ? 16'h1 : since_rise + 16'h1;
    if (!rst_n) begin
      high_len <= 16'h0;
      n_pulses <= 16'h0;
    end else if (!gate && run != 16'h0) begin
      high_len <= run;
      n_pulses <= n_pulses + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // ADC: conversion starts on a rising trigger edge
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    trig_d <= rst_n & trig;
    if (!rst_n) begin
      conv_count <= 16'h0;
      trig_gap <= 16'h0;
      trig_ofs <= 16'h0;
      since_trig <= 16'h0;
    end else if (trig && !trig_d) begin
      conv_count <= conv_count + 16'h1;
      trig_gap <= since_trig;
      trig_ofs <= since_rise;
      since_trig <= 16'h1;
    end else begin
      since_trig <= since_trig + 16'h1;
    end
  end
endmodule // gate_adc_model
`default_nettype wire

// [verif/buck_pwm_subtimer_test.sv]
// Purpose: Self-checking bench for the buck PWM subtimer.
// Assumes: Register map from the package, mclk at 250 MHz.
// Notes: Reset values first, then table rows, then shadow and repetition cases.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("wrong value at %0t: got %0h expected %0h", \
  $time, g, e); end end
module buck_pwm_subtimer_test;
  import buck_pwm_pkg::*;
  typedef struct { int p, d, s, oe, te; } row_t;
  logic mclk, rst_n, channel0_pin, adc_trigger_out_zero, subtimer_irq_line;
  bus_req_t bus_req;
  logic [DATA_W-1:0] rdata, v, v2;
  logic [15:0] high_len, n_pulses, trig_gap, trig_ofs, conv_count;
  int miscompares, check_count;
  time t0;
  // Sample compare kept at half of the duty compare
  row_t rows[3] = '{'{40, 19, 9, 1, 1}, '{25, 0, 0, 1, 1}, '{30, 10, 5, 0, 0}};

  buck_pwm_subtimer u_buck_pwm_subtimer (.mclk(mclk), .rst_n(rst_n),
    .bus_req(bus_req), .rdata(rdata), .channel0_pin(channel0_pin),
    .adc_trigger_out_zero(adc_trigger_out_zero),
    .subtimer_irq_line(subtimer_irq_line));
  gate_adc_model u_gate_adc_model (.mclk(mclk), .rst_n(rst_n),
    .gate(channel0_pin), .trig(adc_trigger_out_zero), .high_len(high_len),
    .n_pulses(n_pulses), .trig_gap(trig_gap), .trig_ofs(trig_ofs),
    .conv_count(conv_count));

  // Clock source
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Reset held for two cycles
  task automatic reset_dut;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  // Bounded wait: 0 irq level, 1 pin level, 2 finished pulse count
  task automatic wait_for(input int what, input int val);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 5000 && !hit; i++) begin
      @(posedge mclk);
      #1;
      case (what)
        0: hit = (subtimer_irq_line === val[0]);
        1: hit = (channel0_pin === val[0]);
        default: hit = (n_pulses == 16'(val));
      endcase
    end
    if (!hit) begin
      miscompares++;
      $display("wait limit reached at %0t for %0d", $time, what);
      complete_run;
    end
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    miscompares = 0;
    check_count = 0;
    reset_dut;
    `CHK(channel0_pin, 1'b0)
    rd(OFS_PERIOD, v);
    `CHK(v, 32'h00008700)
    rd(OFS_DUTY, v);
    `CHK(v, 32'h00000000)
    wr(OFS_COUNT, 32'h00000055);
    rd(OFS_COUNT, v);
    `CHK(v, 32'h00000000)
    rd(8'h3c, v);
    `CHK(v, 32'h00000000)
    $display("test reset values done");
    foreach (rows[i]) begin
      reset_dut;
      wr(OFS_SUB_CTL, 32'h1);
      wr(OFS_PERIOD, 32'(rows[i].p));
      wr(OFS_DUTY, 32'(rows[i].d));
      wr(OFS_SAMPLE, 32'(rows[i].s));
      wr(OFS_CHAN_CFG, 32'h3);
      wr(OFS_ADC_CFG, 32'(rows[i].te));
      wr(OFS_OUT_EN, 32'(rows[i].oe));
      wr(OFS_IRQ_EN, 32'h1);
      wr(OFS_MASTER_CTL, 32'h1);
      repeat (3 * (rows[i].p + 1) + 6) @(posedge mclk);
      #1;
      `CHK(high_len, 16'(rows[i].oe * (rows[i].d + 1)))
      if (rows[i].te != 0) begin
        `CHK(trig_gap, 16'(rows[i].p + 1))
      end else begin
        `CHK(conv_count, 16'h0)
      end
      if (rows[i].te != 0 && rows[i].oe != 0) begin
        `CHK(trig_ofs, 16'(rows[i].s + 1))
      end
      `CHK(subtimer_irq_line, 1'b1)
      rd(OFS_STATUS, v);
      `CHK(v, 32'h00000003)
      wr(OFS_MASTER_CTL, 32'h0);
      rd(OFS_COUNT, v);
      repeat (5) @(posedge mclk);
      rd(OFS_COUNT, v2);
      `CHK(v2, v)
      $display("test row %0d done", i);
    end
    // Shadowed duty with update on counter reset and soft update
    reset_dut;
    wr(OFS_SUB_CTL, 32'h7);
    wr(OFS_PERIOD, 32'd40);
    wr(OFS_DUTY, 32'd5);
    wr(OFS_CHAN_CFG, 32'h3);
    wr(OFS_OUT_EN, 32'h1);
    wr(OFS_SOFT_UPD, 32'h1);
    wr(OFS_MASTER_CTL, 32'h1);
    wait_for(1, 1);
    wr(OFS_DUTY, 32'd15);
    wait_for(2, 1);
    `CHK(high_len, 16'd6)
    wait_for(2, 2);
    `CHK(high_len, 16'd16)
    $display("test shadow done");
    // Repetition interrupt spacing for counts 0 and 2
    for (int rep = 0; rep <= 2; rep += 2) begin
      reset_dut;
      wr(OFS_SUB_CTL, 32'h1);
      wr(OFS_PERIOD, 32'd20);
      wr(OFS_REP, 32'(rep));
      wr(OFS_IRQ_EN, 32'h2);
      wr(OFS_MASTER_CTL, 32'h1);
      wait_for(0, 1);
      t0 = $time;
      wr(OFS_STATUS, 32'h2);
      wait_for(0, 0);
      wait_for(0, 1);
      `CHK(int'(($time - t0) / 4), (rep + 1) * 21)
      $display("test repetition %0d done", rep);
    end
    complete_run;
  end
endmodule // buck_pwm_subtimer_test
`default_nettype wire
